// ==== hw/sxr_standby_reset.sv ====
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sxr_params.svh"

// How it works
// - Any request flag ends standby, resume next
// - Halt exit by flag keeps all state
// - Reset ends either standby mode unconditionally
// - Stay held during reset, then fetch zero
// - Reset exit keeps data memory contents
// - Reset input is active high
// - Reset clears ten-bit program counter
// - Reset clears both skip flags
// - Reset clears eight-bit timer count
// - Reset clears clock select, divide by 256
// - Reset clears all three prescaler stages
// - Reset clears shift mode bits
// - Reset clears both request flags
// - Stack, accumulator, latches need no reset
// - Reset floats every port, inputs mode
// - Set flag blocks entering standby
module sxr_standby_reset #(
  parameter int PC_WIDTH = 10,
  parameter int PORT_COUNT = 16,
  parameter int COUNT_WIDTH = 8
) (
  // Clock and system reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Device reset pin, active high, not synchronous
  input wire logic i_reset_pin,
  // Instruction execution pulses from the core
  input wire logic i_halt_exec,
  input wire logic i_stop_exec,
  input wire logic i_flag_test_exec,
  input wire logic i_timer_exec,
  input wire logic i_serial_exec,
  // Request sources
  input wire logic i_serial_end_source,
  input wire logic i_external_pin,
  // Core state updates
  input wire logic i_pc_load,
  input wire logic [PC_WIDTH-1:0] i_pc_next,
  input wire logic i_skip_load,
  input wire logic [1:0] i_skip_next,
  input wire logic i_port_oe_load,
  input wire logic [PORT_COUNT-1:0] i_port_oe_next,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core control
  output logic o_cpu_run,
  output logic o_osc_run,
  output logic o_init,
  output logic o_fetch_zero,
  output logic [PC_WIDTH-1:0] o_pc,
  output logic [1:0] o_skip_flags,
  // Timer and flags
  output logic [COUNT_WIDTH-1:0] o_timer_count,
  output logic o_timer_request_flag,
  output logic o_shared_request_flag,
  output logic [1:0] o_clock_select,
  output logic [2:0] o_shift_mode,
  // Ports and interrupt
  output logic [PORT_COUNT-1:0] o_port_oe,
  output logic o_irq
);

  // ***************************************************************
  // Parameter checks
  // ***************************************************************
  if (PC_WIDTH < 1 || PORT_COUNT < 1 || COUNT_WIDTH < 8 || COUNT_WIDTH > 16) begin : g_chk
    $error("sxr_standby_reset: unsupported parameter values");
  end

  // ***************************************************************
  // Reset pin synchroniser
  // ***************************************************************
  logic rst_meta;
  logic rst_sync;

  // Two flops; only the second one is looked at
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= i_reset_pin;
      rst_sync <= rst_meta;
    end
  end

  // ***************************************************************
  // Standby state machine
  // ***************************************************************
  sxr_pkg::sxr_state_e state;
  sxr_pkg::sxr_state_e next_state;
  logic any_flag;
  logic init_now;

  assign any_flag = o_timer_request_flag | o_shared_request_flag;
  assign init_now = (next_state == sxr_pkg::SXR_INIT);

  // Next state; reset pin overrides every state
  always_comb begin
    next_state = state;
    if (rst_sync) begin
      next_state = sxr_pkg::SXR_INIT;
    end else begin
      unique case (state)
        sxr_pkg::SXR_RUN: begin
          // A pending flag makes the standby instruction a no-op
          if (!any_flag && i_stop_exec) begin
            next_state = sxr_pkg::SXR_STOP;
          end else if (!any_flag && i_halt_exec) begin
            next_state = sxr_pkg::SXR_HALT;
          end
        end
        sxr_pkg::SXR_HALT, sxr_pkg::SXR_STOP: begin
          if (any_flag) begin
            next_state = sxr_pkg::SXR_RUN;
          end
        end
        sxr_pkg::SXR_INIT: begin
          next_state = sxr_pkg::SXR_RUN;
        end
      endcase
    end
  end

  // State and core control flops
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state <= sxr_pkg::SXR_INIT;
      o_cpu_run <= 1'b0;
      o_osc_run <= 1'b1;
      o_init <= 1'b1;
      o_fetch_zero <= 1'b0;
    end else begin
      state <= next_state;
      o_cpu_run <= (next_state == sxr_pkg::SXR_RUN);
      o_osc_run <= (next_state != sxr_pkg::SXR_STOP);
      o_init <= init_now;
      // One pulse as the core restarts from location zero
      o_fetch_zero <= (state == sxr_pkg::SXR_INIT) && !rst_sync;
    end
  end

  // ***************************************************************
  // Program counter and skip flags
  // ***************************************************************
  // Updates only while running, so a halted core keeps everything.
  // Stack, accumulator, carry, general registers and port latches
  // live in the core and are left alone here.
  always_ff @(posedge i_clock) begin
    if (i_srst || init_now) begin
      o_pc <= '0;
      o_skip_flags <= 2'h0;
    end else if (o_cpu_run) begin
      if (i_pc_load) begin
        o_pc <= i_pc_next;
      end
      if (i_skip_load) begin
        o_skip_flags <= i_skip_next;
      end
    end
  end

  // Port drivers off after reset; data memory is outside.
  always_ff @(posedge i_clock) begin
    if (i_srst || init_now) begin
      o_port_oe <= '0;
    end else if (o_cpu_run && i_port_oe_load) begin
      o_port_oe <= i_port_oe_next;
    end
  end

  // ***************************************************************
  // Prescaler and timer
  // ***************************************************************
  logic [7:0] prescale;
  logic ext_q;
  logic ext_edge;
  logic count_pulse;
  logic overflow;

  assign ext_edge = i_external_pin & ~ext_q;
  assign overflow = count_pulse && (o_timer_count == {COUNT_WIDTH{1'b1}});

  // Count pulse pick from the three prescaler stages or the external pin edge
  always_comb begin
    unique case (o_clock_select)
      `SXR_SEL_DIV256: count_pulse = (prescale == 8'hff);
      `SXR_SEL_DIV32: count_pulse = (prescale[4:0] == 5'h1f);
      `SXR_SEL_DIV4: count_pulse = (prescale[1:0] == 2'h3);
      `SXR_SEL_EXT: count_pulse = ext_edge;
    endcase
  end

  // Prescaler keeps running through standby so the timer can wake us
  always_ff @(posedge i_clock) begin
    if (i_srst || init_now) begin
      prescale <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      prescale <= prescale + 8'h01;
      ext_q <= i_external_pin;
    end
  end

  // Timer count, cleared by reset and by the timer instruction
  always_ff @(posedge i_clock) begin
    if (i_srst || init_now) begin
      o_timer_count <= '0;
    end else if (i_timer_exec && o_cpu_run) begin
      o_timer_count <= '0;
    end else if (count_pulse) begin
      o_timer_count <= o_timer_count + 1'b1;
    end
  end

  // ***************************************************************
  // Request flags
  // ***************************************************************
  logic shared_set;
  logic shared_clr;

  // Select bit picks external edge or serial end as the shared source
  assign shared_set = o_shift_mode[2] ? ext_edge : i_serial_end_source;
  assign shared_clr = o_cpu_run && (i_flag_test_exec || (!o_shift_mode[2] && i_serial_exec));

  // Set beats a clear in the same cycle, so no event is lost
  always_ff @(posedge i_clock) begin
    if (i_srst || init_now) begin
      o_timer_request_flag <= 1'b0;
      o_shared_request_flag <= 1'b0;
    end else begin
      if (overflow) begin
        o_timer_request_flag <= 1'b1;
      end else if (o_cpu_run && (i_flag_test_exec || i_timer_exec)) begin
        o_timer_request_flag <= 1'b0;
      end
      if (shared_set) begin
        o_shared_request_flag <= 1'b1;
      end else if (shared_clr) begin
        o_shared_request_flag <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Register bus
  // ***************************************************************
  logic aw_have;
  logic w_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [`SXR_IRQ_BITS-1:0] irq_stat;
  logic [`SXR_IRQ_BITS-1:0] irq_mask;
  logic [`SXR_IRQ_BITS-1:0] irq_event;
  logic [`SXR_IRQ_BITS-1:0] irq_w1c;

  assign do_write = aw_have && w_have && !s_axi_bvalid;

  // Address and data are caught independently, answered together
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SXR_AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[7:4] == 4'h0) ? `SXR_AXI_OKAY : `SXR_AXI_SLVERR;
      end else if (s_axi_bready) begin
        if (s_axi_bvalid) begin
          aw_have <= 1'b0;
          w_have <= 1'b0;
        end
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; reset pin initialisation wins over software
  always_ff @(posedge i_clock) begin
    if (i_srst || init_now) begin
      o_clock_select <= `SXR_RST_CLKSEL;
      o_shift_mode <= `SXR_RST_SHIFT;
    end else if (do_write && aw_addr == `SXR_OFS_CTRL && w_strb[0]) begin
      o_clock_select <= w_data[`SXR_CTRL_CLKSEL_LSB +: 2];
      o_shift_mode <= w_data[`SXR_CTRL_SHIFT_LSB +: 3];
    end
  end

  // Interrupt mask register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_mask <= `SXR_RST_IRQ_MASK;
    end else if (do_write && aw_addr == `SXR_OFS_IRQ_MASK && w_strb[0]) begin
      irq_mask <= w_data[`SXR_IRQ_BITS-1:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  assign irq_event[`SXR_IRQ_WAKE_FLAG] = (state == sxr_pkg::SXR_HALT ||
      state == sxr_pkg::SXR_STOP) && next_state == sxr_pkg::SXR_RUN;
  assign irq_event[`SXR_IRQ_WAKE_RESET] = (state == sxr_pkg::SXR_INIT) && !rst_sync;
  assign irq_event[`SXR_IRQ_TIMER_OVF] = overflow;
  assign irq_w1c = (do_write && aw_addr == `SXR_OFS_IRQ_STAT && w_strb[0]) ?
      w_data[`SXR_IRQ_BITS-1:0] : '0;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_stat <= '0;
      o_irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_w1c) | irq_event;
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  // Read channel, one answer per accepted address
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SXR_AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SXR_AXI_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        unique case (s_axi_araddr)
          `SXR_OFS_CTRL: begin
            s_axi_rdata[`SXR_CTRL_CLKSEL_LSB +: 2] <= o_clock_select;
            s_axi_rdata[`SXR_CTRL_SHIFT_LSB +: 3] <= o_shift_mode;
          end
          `SXR_OFS_STATUS: begin
            s_axi_rdata[`SXR_STAT_STATE_LSB +: 2] <= state;
            s_axi_rdata[`SXR_STAT_TFLAG_BIT] <= o_timer_request_flag;
            s_axi_rdata[`SXR_STAT_SFLAG_BIT] <= o_shared_request_flag;
            s_axi_rdata[`SXR_STAT_COUNT_LSB +: COUNT_WIDTH] <= o_timer_count;
          end
          `SXR_OFS_IRQ_STAT: s_axi_rdata[`SXR_IRQ_BITS-1:0] <= irq_stat;
          `SXR_OFS_IRQ_MASK: s_axi_rdata[`SXR_IRQ_BITS-1:0] <= irq_mask;
          default: s_axi_rresp <= `SXR_AXI_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  sequence s_asleep_flagged;
    (state == sxr_pkg::SXR_HALT || state == sxr_pkg::SXR_STOP) && any_flag && !rst_sync;
  endsequence

  sequence s_reset_release;
    o_init && !rst_sync;
  endsequence

  a_flag_wakes_core: assert property (s_asleep_flagged |=> o_cpu_run && !o_init)
    else $error("flag did not end standby");
  // A reset pin during halt may clear the core, so it is left out here
  a_halt_keeps_pc: assert property (state == sxr_pkg::SXR_HALT && !rst_sync
      |=> $stable(o_pc) && $stable(o_skip_flags))
    else $error("pc changed while halted");
  a_reset_cancels: assert property (rst_sync |=> o_init && !o_cpu_run)
    else $error("reset did not cancel standby");
  a_release_fetch_zero: assert property (s_reset_release |=> o_fetch_zero && o_cpu_run)
    else $error("no restart after reset release");
  a_pin_sync_delay: assert property ($rose(i_reset_pin) |-> ##3 o_init)
    else $error("reset pin not seen after two stages");
  a_init_clears_core: assert property (o_init |-> o_pc == '0 && o_skip_flags == 2'h0)
    else $error("pc or skip flags not cleared");
  a_init_clears_timer: assert property (o_init |-> o_timer_count == '0 && prescale == 8'h00)
    else $error("timer or prescaler not cleared");
  a_init_clears_modes: assert property (o_init |-> o_clock_select == 2'h0 && o_shift_mode == 3'h0)
    else $error("mode bits not cleared");
  a_init_clears_flags: assert property (o_init |-> !o_timer_request_flag && !o_shared_request_flag)
    else $error("request flags not cleared");
  a_ports_float: assert property (o_init |-> o_port_oe == '0)
    else $error("port drivers left on in reset");
  a_flag_blocks_sleep: assert property (state == sxr_pkg::SXR_RUN && any_flag
      && !rst_sync |=> state == sxr_pkg::SXR_RUN)
    else $error("standby entered with flag set");

endmodule

// ==== hw/sxr_params.svh ====
`ifndef SXR_PARAMS_SVH
`define SXR_PARAMS_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define SXR_OFS_CTRL 8'h00
`define SXR_OFS_STATUS 8'h04
`define SXR_OFS_IRQ_STAT 8'h08
`define SXR_OFS_IRQ_MASK 8'h0c

// ***************************************************************
// Control register fields
// ***************************************************************
`define SXR_CTRL_CLKSEL_LSB 0
`define SXR_CTRL_SHIFT_LSB 4
`define SXR_CTRL_SRCSEL_BIT 6

// ***************************************************************
// Status register fields
// ***************************************************************
`define SXR_STAT_STATE_LSB 0
`define SXR_STAT_TFLAG_BIT 2
`define SXR_STAT_SFLAG_BIT 3
`define SXR_STAT_COUNT_LSB 8

// ***************************************************************
// Interrupt status bits
// ***************************************************************
`define SXR_IRQ_WAKE_FLAG 0
`define SXR_IRQ_WAKE_RESET 1
`define SXR_IRQ_TIMER_OVF 2
`define SXR_IRQ_BITS 3

// ***************************************************************
// Reset values, count-pulse selections and bus responses
// ***************************************************************
`define SXR_RST_CLKSEL 2'h0
`define SXR_RST_SHIFT 3'h0
`define SXR_RST_IRQ_MASK 3'h0
`define SXR_SEL_DIV256 2'h0
`define SXR_SEL_DIV32 2'h1
`define SXR_SEL_DIV4 2'h2
`define SXR_SEL_EXT 2'h3
`define SXR_AXI_OKAY 2'h0
`define SXR_AXI_SLVERR 2'h2

`endif

// ==== hw/sxr_pkg.sv ====
package sxr_pkg;

  // Gray codes along run -> halt -> stop, init beside
  typedef enum logic [1:0] {
    SXR_RUN = 2'h0,
    SXR_HALT = 2'h1,
    SXR_STOP = 2'h3,
    SXR_INIT = 2'h2
  } sxr_state_e;

endpackage

// ==== dv/sxr_req_src.sv ====
`timescale 1ns/1ps

// ***************************************************************
// Reset source and request sources facing the block
// ***************************************************************
module sxr_req_src (
  // Clock
  input wire logic i_clock,
  // Requests from the bench
  input wire logic i_rst_req,
  input wire logic i_ser_req,
  input wire logic i_ext_req,
  // Pins toward the block
  output logic o_reset_pin,
  output logic o_serial_end_source,
  output logic o_external_pin
);
  // Reset pin moves off the clock edge, so the synchroniser is really exercised
  initial o_reset_pin = 1'b0;
  always @(i_rst_req) o_reset_pin <= #2 i_rst_req;
  // Transfer-end strobe lasts exactly one clock
  initial o_serial_end_source = 1'b0;
  always @(posedge i_clock) o_serial_end_source <= i_ser_req;
  // External pin is a level that moves 1.3 ns after the clock edge
  initial o_external_pin = 1'b0;
  always @(i_ext_req) o_external_pin <= #1.3 i_ext_req;
endmodule

// ==== dv/sxr_standby_reset_tb.sv ====
`timescale 1ns/1ps
`include "sxr_params.svh"

// ***************************************************************
// Bench for standby exit and reset initialisation
// ***************************************************************
module sxr_standby_reset_tb;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [4:0] ex = 5'h00;
  logic rst_req = 1'b0;
  logic ser_req = 1'b0;
  logic ext_req = 1'b0;
  logic pc_ld = 1'b0;
  logic sk_ld = 1'b0;
  logic oe_ld = 1'b0;
  logic [9:0] pc_nx = 10'h000;
  logic [1:0] sk_nx = 2'h0;
  logic [15:0] oe_nx = 16'h0000;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, skip, csel;
  logic [31:0] rdata, rd;
  logic rpin, send, epin, run, osc, init, fz, tflag, sflag, irq;
  logic [9:0] pc;
  logic [7:0] count;
  logic [2:0] smode;
  logic [15:0] oe;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  sxr_standby_reset dut (
    .i_clock(i_clock), .i_srst(i_srst), .i_reset_pin(rpin),
    .i_halt_exec(ex[0]), .i_stop_exec(ex[1]), .i_flag_test_exec(ex[2]),
    .i_timer_exec(ex[3]), .i_serial_exec(ex[4]),
    .i_serial_end_source(send), .i_external_pin(epin),
    .i_pc_load(pc_ld), .i_pc_next(pc_nx), .i_skip_load(sk_ld), .i_skip_next(sk_nx),
    .i_port_oe_load(oe_ld), .i_port_oe_next(oe_nx),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .o_cpu_run(run), .o_osc_run(osc), .o_init(init), .o_fetch_zero(fz), .o_pc(pc),
    .o_skip_flags(skip), .o_timer_count(count), .o_timer_request_flag(tflag),
    .o_shared_request_flag(sflag), .o_clock_select(csel), .o_shift_mode(smode),
    .o_port_oe(oe), .o_irq(irq)
  );

  sxr_req_src far (
    .i_clock(i_clock), .i_rst_req(rst_req), .i_ser_req(ser_req), .i_ext_req(ext_req),
    .o_reset_pin(rpin), .o_serial_end_source(send), .o_external_pin(epin)
  );

  // 200 MHz clock
  always #2.5 i_clock = ~i_clock;

  // Watchdog, far above the little over a thousand cycles the tests need
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // One-cycle instruction strobe, then a free edge so it is never reassigned at once
  task automatic pulse(input int k);
    ex[k] <= 1'b1;
    tick(1);
    ex[k] <= 1'b0;
    tick(1);
  endtask

  task automatic ser();
    ser_req <= 1'b1;
    tick(1);
    ser_req <= 1'b0;
    tick(4);
  endtask

  // Slow edge so the single-flop edge detector sees it
  task automatic ext_edge();
    ext_req <= 1'b1;
    tick(4);
    ext_req <= 1'b0;
    tick(4);
  endtask

  task automatic core_load(input logic [9:0] p);
    pc_nx <= p;
    pc_ld <= 1'b1;
    tick(1);
    pc_ld <= 1'b0;
  endtask

  // Address and data offered together; each released at its own handshake
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_clock);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge i_clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    tick(1);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge i_clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_clock); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk(32'(rresp), 32'(er));
    tick(1);
  endtask

  // Everything but the prescaler that initialisation must leave cleared
  task automatic zeros();
    chk(32'(pc), 32'h0);
    chk(32'(skip), 32'h0);
    chk(32'(count), 32'h0);
    chk(32'(csel), 32'(`SXR_SEL_DIV256));
    chk(32'(smode), 32'h0);
    chk(32'({tflag, sflag}), 32'h0);
    chk(32'(oe), 32'h0);
  endtask

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    tick(4);
    i_srst <= 1'b0;
    while (fz !== 1'b1) tick(1);
    chk(32'(run), 32'h1);
    zeros();
    $display("test power-up done");
    // Dirty every piece of state but the timer request flag, then pull the reset pin
    sk_nx <= 2'h3;
    oe_nx <= 16'hffff;
    sk_ld <= 1'b1;
    oe_ld <= 1'b1;
    core_load(10'h2a5);
    sk_ld <= 1'b0;
    oe_ld <= 1'b0;
    tick(1);
    chk(32'({pc, skip, oe}), 32'({10'h2a5, 2'h3, 16'hffff}));
    axw(`SXR_OFS_CTRL, 32'h0000_0043, `SXR_AXI_OKAY);
    axr(`SXR_OFS_CTRL, rd, `SXR_AXI_OKAY);
    chk(rd, 32'h0000_0043);
    repeat (3) ext_edge();
    chk(32'({count, sflag}), 32'({8'h03, 1'b1}));
    pulse(3);
    chk(32'(count), 32'h0);
    ext_edge();
    rst_req <= 1'b1;
    tick(10);
    chk(32'({init, run}), 32'h2);
    zeros();
    axr(`SXR_OFS_CTRL, rd, `SXR_AXI_OKAY);
    chk(rd, 32'h0);
    chk(32'(init), 32'h1);
    rst_req <= 1'b0;
    while (fz !== 1'b1) tick(1);
    chk(32'({run, pc}), 32'({1'b1, 10'h000}));
    $display("test reset pin done");
    // Halt, refused core update, wake by the transfer-end flag
    axw(`SXR_OFS_IRQ_MASK, 32'h1, `SXR_AXI_OKAY);
    core_load(10'h15a);
    tick(1);
    pulse(0);
    tick(2);
    chk(32'(run), 32'h0);
    core_load(10'h3ff);
    ser();
    while (run !== 1'b1) tick(1);
    chk(32'(pc), 32'h15a);
    tick(3);
    chk(32'(irq), 32'h1);
    axr(`SXR_OFS_IRQ_STAT, rd, `SXR_AXI_OKAY);
    chk(rd & 32'h1, 32'h1);
    axw(`SXR_OFS_IRQ_STAT, 32'h7, `SXR_AXI_OKAY);
    axr(`SXR_OFS_IRQ_STAT, rd, `SXR_AXI_OKAY);
    chk(rd, 32'h0);
    tick(2);
    chk(32'(irq), 32'h0);
    $display("test halt wake done");
    // A set flag refuses standby; then stop and leave by the reset pin
    pulse(1);
    tick(3);
    chk(32'({run, osc, sflag}), 32'h7);
    pulse(4);
    chk(32'(sflag), 32'h0);
    pulse(1);
    tick(3);
    chk(32'({run, osc}), 32'h0);
    rst_req <= 1'b1;
    tick(6);
    chk(32'({init, osc}), 32'h3);
    rst_req <= 1'b0;
    while (fz !== 1'b1) tick(1);
    chk(32'(run), 32'h1);
    ser();
    chk(32'(sflag), 32'h1);
    pulse(2);
    chk(32'(sflag), 32'h0);
    $display("test stop and reset done");
    // Unmapped place read and write, then a status read
    axr(8'h40, rd, `SXR_AXI_SLVERR);
    chk(rd, 32'h0);
    axw(8'h40, 32'h1, `SXR_AXI_SLVERR);
    axr(`SXR_OFS_STATUS, rd, `SXR_AXI_OKAY);
    chk(rd & 32'hf, 32'h0);
    $display("test bus errors done");
    // Fast count pulse, halt, then wake by the timer overflow flag
    axw(`SXR_OFS_CTRL, 32'(`SXR_SEL_DIV4), `SXR_AXI_OKAY);
    pulse(0);
    chk(32'({run, tflag}), 32'h0);
    while (run !== 1'b1) tick(1);
    chk(32'(tflag), 32'h1);
    axr(`SXR_OFS_IRQ_STAT, rd, `SXR_AXI_OKAY);
    chk(rd & 32'h4, 32'h4);
    pulse(3);
    chk(32'(tflag), 32'h0);
    $display("test timer wake done");
    end_sim();
  end
endmodule
